// [design/ssd_pkg.sv]
// Purpose: Shared constants for the subtract, swap and table read datapath.
// Assumes: 8-bit data, 14-bit program words, 11-bit table addresses.
// Notes:   Operation codes are one-hot and come from the decoder.
package ssd_pkg;
  localparam int DATA_W   = 8;
  localparam int ROM_W    = 14;
  localparam int FADDR_W  = 6;
  localparam int PTR_LO_W = 3;
  localparam int ROM_AW   = PTR_LO_W + DATA_W;
  localparam int HIGH_W   = ROM_W - DATA_W;
  localparam int NIB_LO   = 0;
  localparam int NIB_HI   = 4;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [DATA_W-1:0] THD_RST = 8'h00;
  localparam int TABLE_CYCLES = 2;
  localparam int SINGLE_CYCLES = 1;
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [4:0] {
    SSD_OP_NONE  = 5'b00001,
    SSD_OP_SUBF  = 5'b00010,
    SSD_OP_SWAP  = 5'b00100,
    SSD_OP_SUBI  = 5'b01000,
    SSD_OP_TABLE = 5'b10000
  } ssd_op_t;

  typedef enum logic [1:0] {
    SSD_ST_IDLE = 2'b01,
    SSD_ST_ROM  = 2'b10
  } ssd_state_t;
endpackage

// [design/ssd_rom.sv]
// Purpose: Program ROM table with registered read data.
// Assumes: Contents supplied as a parameter constant.
// Notes:   Data appear one cycle after the address is sampled.
`timescale 1ns/100ps
`default_nettype none
module ssd_rom #(
  parameter int AW = 11,
  parameter int DW = 14,
  parameter logic [DW-1:0] INIT [2**AW] = '{default: '0}
) (
  input  wire logic          mclk_i,
  input  wire logic          ce_i,
  input  wire logic [AW-1:0] addr_i,
  output logic      [DW-1:0] data_o
);
  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      data_o <= INIT[addr_i];
    end
  end
endmodule
`default_nettype wire

// [design/ssd_datapath.sv]
// Purpose: Execution datapath for file subtract, nibble swap, immediate
//          subtract and table read.
// Assumes: Decoder holds op and operands stable for each instruction.
// Notes:   Table read stalls the decoder via busy_o for one extra cycle.
`timescale 1ns/100ps
`default_nettype none
module ssd_datapath #(
  parameter logic [ssd_pkg::ROM_W-1:0] ROM_INIT [2**ssd_pkg::ROM_AW] =
    '{default: '0}
) (
  input  wire logic                         mclk_i,
  input  wire logic                         nrst_i,
  input  wire logic                         ce_i,
  input  wire ssd_pkg::ssd_op_t             op_i,
  input  wire logic                         dest_sel_i,
  input  wire logic [ssd_pkg::FADDR_W-1:0]  file_addr_i,
  input  wire logic [ssd_pkg::DATA_W-1:0]   file_data_i,
  input  wire logic [ssd_pkg::DATA_W-1:0]   immediate_i,
  input  wire logic [ssd_pkg::DATA_W-1:0]   table_high_pointer_i,
  output logic      [ssd_pkg::DATA_W-1:0]   accumulator_o,
  output logic      [ssd_pkg::DATA_W-1:0]   table_high_data_o,
  output logic                              zero_flag_o,
  output logic                              digit_carry_flag_o,
  output logic                              carry_flag_o,
  output logic                              file_we_o,
  output logic      [ssd_pkg::FADDR_W-1:0]  file_waddr_o,
  output logic      [ssd_pkg::DATA_W-1:0]   file_wdata_o,
  output logic                              busy_o
);
  import ssd_pkg::*;

  // ------------------------------------------------------------
  // Arithmetic
  // ------------------------------------------------------------
  // Subtraction done as a + ~b + 1 so carry out means no borrow.
  function automatic logic [DATA_W+1:0] sub_f(
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b
  );
    logic [DATA_W:0] full;
    logic [4:0]      low;
    full = {1'b0, a} + {1'b0, ~b} + 9'h001;
    low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    return {low[4], full};
  endfunction

  logic [DATA_W+1:0]  subf_res;
  logic [DATA_W+1:0]  subi_res;
  logic [DATA_W-1:0]  swap_res;
  logic               start_table;
  logic [ROM_AW-1:0]  rom_addr;
  logic [ROM_W-1:0]   rom_data;
  ssd_state_t         state_q;

  assign subf_res = sub_f(file_data_i, accumulator_o);
  assign subi_res = sub_f(immediate_i, accumulator_o);
  assign swap_res = {file_data_i[NIB_LO+:4], file_data_i[NIB_HI+:4]};
  assign start_table = (state_q == SSD_ST_IDLE) && (op_i == SSD_OP_TABLE);
  assign rom_addr = {table_high_pointer_i[PTR_LO_W-1:0], accumulator_o};

  ssd_rom #(
    .AW   (ROM_AW),
    .DW   (ROM_W),
    .INIT (ROM_INIT)
  ) u_rom (
    .mclk_i (mclk_i),
    .ce_i   (ce_i & start_table),
    .addr_i (rom_addr),
    .data_o (rom_data)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Table read spends the first cycle fetching, the second loading.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_q <= SSD_ST_IDLE;
      busy_o  <= 1'b0;
    end else if (ce_i) begin
      unique case (state_q)
        SSD_ST_IDLE: begin
          if (start_table) begin
            state_q <= SSD_ST_ROM;
            busy_o  <= 1'b1;
          end
        end
        SSD_ST_ROM: begin
          state_q <= SSD_ST_IDLE;
          busy_o  <= 1'b0;
        end
        default: begin
          state_q <= SSD_ST_IDLE;
          busy_o  <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Accumulator and table high data
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      accumulator_o     <= ACC_RST;
      table_high_data_o <= THD_RST;
    end else if (ce_i) begin
      if (state_q == SSD_ST_ROM) begin
        accumulator_o     <= rom_data[DATA_W-1:0];
        table_high_data_o <= {2'b00, rom_data[ROM_W-1:DATA_W]};
      end else if (op_i == SSD_OP_SUBI) begin
        accumulator_o <= subi_res[DATA_W-1:0];
      end else if (op_i == SSD_OP_SUBF && dest_sel_i == DEST_ACC) begin
        accumulator_o <= subf_res[DATA_W-1:0];
      end else if (op_i == SSD_OP_SWAP && dest_sel_i == DEST_ACC) begin
        accumulator_o <= swap_res;
      end
    end
  end

  // ------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      zero_flag_o        <= 1'b0;
      digit_carry_flag_o <= 1'b0;
      carry_flag_o       <= 1'b0;
    end else if (ce_i && state_q == SSD_ST_IDLE) begin
      if (op_i == SSD_OP_SUBF) begin
        zero_flag_o        <= (subf_res[DATA_W-1:0] == 8'h00);
        digit_carry_flag_o <= subf_res[DATA_W+1];
        carry_flag_o       <= subf_res[DATA_W];
      end else if (op_i == SSD_OP_SUBI) begin
        zero_flag_o        <= (subi_res[DATA_W-1:0] == 8'h00);
        digit_carry_flag_o <= subi_res[DATA_W+1];
        carry_flag_o       <= subi_res[DATA_W];
      end
    end
  end

  // ------------------------------------------------------------
  // File write-back
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      file_we_o    <= 1'b0;
      file_waddr_o <= '0;
      file_wdata_o <= 8'h00;
    end else if (ce_i) begin
      file_we_o    <= (state_q == SSD_ST_IDLE) && (dest_sel_i == DEST_FILE)
                      && (op_i == SSD_OP_SUBF || op_i == SSD_OP_SWAP);
      file_waddr_o <= file_addr_i;
      file_wdata_o <= (op_i == SSD_OP_SWAP) ? swap_res
                                            : subf_res[DATA_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_SUBI_ACC: assert property (@(posedge mclk_i)
    disable iff (!nrst_i)
    ce_i && state_q == SSD_ST_IDLE && op_i == SSD_OP_SUBI |=>
    accumulator_o == $past(immediate_i) - $past(accumulator_o))
    else $error("Immediate subtract result wrong.");
  AST_SUBF_CARRY: assert property (@(posedge mclk_i)
    disable iff (!nrst_i)
    ce_i && state_q == SSD_ST_IDLE && op_i == SSD_OP_SUBF |=>
    carry_flag_o == ($past(file_data_i) >= $past(accumulator_o)))
    else $error("Carry does not reflect borrow.");
  AST_SUBI_DC: assert property (@(posedge mclk_i)
    disable iff (!nrst_i)
    ce_i && state_q == SSD_ST_IDLE && op_i == SSD_OP_SUBI |=>
    digit_carry_flag_o ==
    ($past(immediate_i[3:0]) >= $past(accumulator_o[3:0])))
    else $error("Digit carry does not reflect nibble borrow.");
  AST_ZERO: assert property (@(posedge mclk_i)
    disable iff (!nrst_i)
    ce_i && state_q == SSD_ST_IDLE && op_i == SSD_OP_SUBI |=>
    zero_flag_o == ($past(immediate_i) == $past(accumulator_o)))
    else $error("Zero flag wrong.");
  AST_SUBF_DEST: assert property (@(posedge mclk_i)
    disable iff (!nrst_i)
    ce_i && state_q == SSD_ST_IDLE && op_i == SSD_OP_SUBF
    && dest_sel_i |=> file_we_o && file_wdata_o ==
    $past(file_data_i) - $past(accumulator_o))
    else $error("File subtract write-back wrong.");
  AST_SWAP: assert property (@(posedge mclk_i)
    disable iff (!nrst_i)
    ce_i && state_q == SSD_ST_IDLE && op_i == SSD_OP_SWAP && !dest_sel_i
    |=> accumulator_o == {$past(file_data_i[3:0]),
    $past(file_data_i[7:4])} && !file_we_o)
    else $error("Swap to accumulator wrong.");
  // A stalled second cycle stretches the read, so it is excused here.
  AST_TABLE_LEN: assert property (@(posedge mclk_i)
    disable iff (!nrst_i)
    ce_i && start_table |=> busy_o ##1 (!busy_o || !$past(ce_i)))
    else $error("Table read length wrong.");
  AST_TABLE_HIGH: assert property (@(posedge mclk_i)
    disable iff (!nrst_i)
    ce_i && state_q == SSD_ST_ROM |=>
    table_high_data_o[7:6] == 2'b00 &&
    table_high_data_o[5:0] == $past(rom_data[13:8]))
    else $error("Table high data wrong.");
  AST_TABLE_LOW: assert property (@(posedge mclk_i)
    disable iff (!nrst_i)
    ce_i && state_q == SSD_ST_ROM |=>
    accumulator_o == $past(rom_data[7:0]))
    else $error("Table low byte wrong.");
  AST_FREEZE: assert property (@(posedge mclk_i)
    disable iff (!nrst_i)
    !ce_i |=> $stable(accumulator_o) && $stable(busy_o)
    && $stable(table_high_data_o) && $stable(carry_flag_o))
    else $error("State moved while clock enable was low.");
  COV_SUBF: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    ce_i && op_i == SSD_OP_SUBF && dest_sel_i);
  COV_BORROW: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    ce_i && op_i == SSD_OP_SUBI && immediate_i < accumulator_o);
  COV_TABLE: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    ce_i && start_table ##1 ce_i ##1 !busy_o);
  COV_FREEZE: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    !ce_i && busy_o);
endmodule
`default_nettype wire

// [tb/ssd_file_model.sv]
// Purpose: File register bank on the far side of the datapath.
// Assumes: Reads are combinational, writes land on the rising edge.
// Notes:   Contents start from a fixed pattern so expectations repeat.
`timescale 1ns/100ps
`default_nettype none
module ssd_file_model (
  input  wire logic       mclk_i,
  input  wire logic [5:0] raddr_i,
  output logic      [7:0] rdata_o,
  input  wire logic       we_i,
  input  wire logic [5:0] waddr_i,
  input  wire logic [7:0] wdata_i
);
  logic [7:0] mem [64];
  initial for (int i = 0; i < 64; i++) mem[i] = 8'(i * 37 + 5);
  assign rdata_o = mem[raddr_i];
  always @(posedge mclk_i) if (we_i) mem[waddr_i] <= wdata_i;
endmodule
`default_nettype wire

// [tb/test_subtract_swap_table_read_datapath.sv]
// Purpose: Self-checking bench for the subtract, swap and table datapath.
// Assumes: Decoder role played here, file bank by ssd_file_model.
// Notes:   An idle cycle follows file writes so the bank settles first.
`timescale 1ns/100ps
`default_nettype none
module test_subtract_swap_table_read_datapath;
  import ssd_pkg::*;
  typedef logic [ROM_W-1:0] ssd_rom_t [2**ROM_AW];
  function automatic logic [13:0] rw(input int a);
    if (a == 'h234) return 14'h35AA;
    return 14'(a * 'h1F3 ^ 'h2A5C);
  endfunction
  function automatic ssd_rom_t mk_rom();
    ssd_rom_t r;
    for (int i = 0; i < 2**ROM_AW; i++) r[i] = rw(i);
    return r;
  endfunction
  logic clk, nrst = 0, ce = 1, dst = 0;
  ssd_op_t op = SSD_OP_NONE;
  logic [5:0] fa = 0, wa;
  logic [7:0] imm = 0, ptr = 0, fd, acc, thd, wd;
  logic z, dc, cf, we, busy;
  logic [7:0] e_acc = 0, e_thd = 0;
  logic [13:0] tw;
  logic e_z = 0, e_dc = 0, e_c = 0;
  int num_errors = 0, checks = 0;
  ssd_op_t ops [4] = '{SSD_OP_SUBF, SSD_OP_SWAP, SSD_OP_SUBI, SSD_OP_TABLE};
  ssd_datapath #(.ROM_INIT(mk_rom())) DUT (.mclk_i(clk), .nrst_i(nrst),
    .ce_i(ce), .op_i(op), .dest_sel_i(dst), .file_addr_i(fa),
    .file_data_i(fd), .immediate_i(imm), .table_high_pointer_i(ptr),
    .accumulator_o(acc), .table_high_data_o(thd), .zero_flag_o(z),
    .digit_carry_flag_o(dc), .carry_flag_o(cf), .file_we_o(we),
    .file_waddr_o(wa), .file_wdata_o(wd), .busy_o(busy));
  ssd_file_model u_file (.mclk_i(clk), .raddr_i(fa), .rdata_o(fd),
    .we_i(we), .waddr_i(wa), .wdata_i(wd));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task chk(input string n, input logic [13:0] s, input logic [13:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Drives one instruction at the falling edge and checks its outcome.
  task run(input ssd_op_t o, input logic d, input logic [5:0] a,
           input logic [7:0] i, input logic [7:0] p);
    logic [7:0] r, opnd, res;
    logic [13:0] w;
    logic wr;
    r = u_file.mem[a];
    opnd = (o == SSD_OP_SUBI) ? i : r;
    wr = 0;
    res = 0;
    op = o; dst = d; fa = a; imm = i; ptr = p;
    if (o == SSD_OP_SUBF || o == SSD_OP_SUBI) begin
      res = opnd - e_acc;
      e_c = opnd >= e_acc;
      e_dc = opnd[3:0] >= e_acc[3:0];
      e_z = res == 0;
      wr = (o == SSD_OP_SUBF) && d;
    end else if (o == SSD_OP_SWAP) begin
      res = {r[3:0], r[7:4]};
      wr = d;
    end else begin
      w = rw({21'h0, p[2:0], e_acc});
      res = w[7:0];
      e_thd = {2'b00, w[13:8]};
    end
    if (!wr) e_acc = res;
    @(posedge clk);
    @(negedge clk);
    op = SSD_OP_NONE;
    if (o == SSD_OP_TABLE) begin
      chk("busy", busy, 1'b1);
      @(posedge clk);
      @(negedge clk);
    end
    chk("busy", busy, 1'b0);
    chk("we", we, wr);
    if (wr) chk("wdata", {wa, wd}, {a, res});
    chk("acc", acc, e_acc);
    chk("thd", thd, e_thd);
    chk("flags", {z, dc, cf}, {e_z, e_dc, e_c});
    if (wr) @(negedge clk);
  endtask
  initial begin
    void'($urandom(32'h0E60BD11));
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk("reset", {acc, thd[5:0]}, 14'h0000);
    chk("reset flags", {z, dc, cf, we, busy}, 14'h0000);
    nrst = 1;
    run(SSD_OP_SUBI, 0, 0, 8'h34, 0);
    run(SSD_OP_TABLE, 0, 0, 0, 8'h02);
    run(SSD_OP_SUBI, 0, 0, 8'hB0, 0);
    run(SSD_OP_SUBI, 0, 0, 8'h05, 0);
    run(SSD_OP_SWAP, 1, 6'h3F, 0, 0);
    run(SSD_OP_SUBF, 1, 6'h3F, 0, 8'hFF);
    // Clock enable low must freeze everything, a table read included.
    ce = 0;
    op = SSD_OP_SUBI;
    imm = 8'($urandom);
    @(posedge clk);
    @(negedge clk);
    chk("frozen acc", acc, e_acc);
    chk("frozen flags", {z, dc, cf}, {e_z, e_dc, e_c});
    chk("frozen we", we, 1'b0);
    ce = 1;
    op = SSD_OP_TABLE;
    ptr = 8'h05;
    tw = rw({21'h0, 3'h5, e_acc});
    @(posedge clk);
    @(negedge clk);
    ce = 0;
    op = SSD_OP_NONE;
    @(posedge clk);
    @(negedge clk);
    chk("stalled busy", busy, 1'b1);
    chk("stalled acc", acc, e_acc);
    chk("stalled thd", thd, e_thd);
    ce = 1;
    @(posedge clk);
    @(negedge clk);
    e_acc = tw[7:0];
    e_thd = {2'b00, tw[13:8]};
    chk("resumed busy", busy, 1'b0);
    chk("resumed acc", acc, e_acc);
    chk("resumed thd", thd, e_thd);
    repeat (300)
      run(ops[$urandom_range(3)], 1'($urandom), 6'($urandom),
          8'($urandom), 8'($urandom));
    end_of_test;
  end
  initial begin
    #400000;
    num_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
